// *** hw/event_sequence_config.sv ***
/*
  event-sequence setup register with apb access; applies calibration to
  measurements, raises autocalibration requests and drives the
  temperature sequencer. assumes apb master on clk, port_done from a pin.
*/
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - calibration bit applies stored factors to measurements taken during an event command
// - autocal codes 0-3 off, 4-7 pick trigger points
// - port code chooses ports and their order
// - preamble count sets dummy passes, zero none
// - each preamble pass uses configured port order
module event_sequence_config (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       psel,           // apb select
  input  wire logic                       penable,        // apb access phase
  input  wire logic                       pwrite,         // apb direction
  input  wire logic [11:0]                paddr,          // apb byte address
  input  wire logic [31:0]                pwdata,         // apb write data
  input  wire logic [3:0]                 pstrb,          // apb byte lanes
  output logic                            pready,         // apb ready
  output logic [31:0]                     prdata,         // apb read data
  output logic                            pslverr,        // apb error
  input  wire logic                       evt_active,     // event command running
  input  wire logic                       tof_cycle_start,// flight_time_difference cycle
  input  wire logic                       tof_seq_start,  // flight_time_difference sequence
  input  wire logic                       temp_go,        // start temperature sequence
  input  wire logic                       port_done_pin,  // conversion done pin
  input  wire logic [31:0]                meas_in,        // raw measurement
  input  wire logic                       meas_in_valid,  // raw measurement strobe
  input  wire logic [15:0]                cal_factor_integer,  // integer factor
  input  wire logic [15:0]                cal_factor_fraction, // fraction factor
  output logic [31:0]                     meas_out,       // measurement out
  output logic                            meas_out_valid, // output strobe
  output logic                            calibrate_req,  // run calibrate command
  output logic [3:0]                      port_stim,      // temperature port drive
  output logic                            store_result,   // temperature result keep
  output logic [1:0]                      result_port,    // port of that result
  output logic                            temp_busy       // temperature sequence busy
);
  import evtseq_pkg::*;

  logic [15:0] setup;         // event_sequence_setup register
  logic        done_meta;     // port_done first stage
  logic        done_sync;     // port_done second stage
  logic        seq_start;     // temperature sequence begins
  logic        cycle_start;   // temperature pass begins
  logic        in_preamble;   // preamble pass running

  // the setup word is the only writable state here; every field below is a
  // plain slice of it, so a host write takes effect on the next clock and
  // the sequencer snapshots what it needs when a sequence starts
  // field views
  wire [4:0] temp_cycle_count     = setup[CYC_CNT_LSB +: 5];
  wire       cal_use              = setup[CAL_USE_BIT];
  wire [2:0] cal_cfg              = setup[CAL_CFG_LSB +: 3];
  wire [1:0] temp_port_select     = setup[PORT_SEL_LSB +: 2];
  wire [2:0] preamble_cycle_count = setup[PRE_LSB +: 3];

  // apb slave with no wait states: the access phase always ends in one
  // cycle, so read data and the error flag are pure decode of the request;
  // writes to the status and result words are dropped without an error,
  // only addresses outside the map answer pslverr
  // apb decode
  wire acc      = psel && penable;
  wire hit_set  = (paddr == OFS_SETUP);
  wire hit_stat = (paddr == OFS_STATUS);
  wire hit_res  = (paddr == OFS_RESULT);
  wire mapped   = hit_set || hit_stat || hit_res;
  wire wr_set   = acc && pwrite && hit_set;
  // status word: cal_use, calibrate_req, temp_busy, in_preamble, result_port
  wire [31:0] status_word = {26'h0000000, result_port, in_preamble, temp_busy,
                             calibrate_req, cal_use};
  // read mux: setup, status, result, else zero
  wire [31:0] rd_word = hit_set ? {16'h0000, setup} :
                        hit_stat ? status_word :
                        hit_res ? meas_out : 32'h00000000;

  assign pready  = 1'b1;                 // zero wait states
  assign pslverr = acc && !mapped;       // unmapped address answers an error
  assign prdata  = (acc && !pwrite) ? rd_word : 32'h00000000;

  // reset value is all zero: autocal off, ports 1 and 3, no preamble
  // upper lanes hold nothing, so pstrb[3:2] are ignored; bits 1:0 keep the
  // port timing code, stored only; a write during a sequence leaves the
  // running sequence alone, since the engine works from its snapshot
  // setup register writes by byte lane
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup <= SETUP_RESET;
    end else if (wr_set) begin
      if (pstrb[0]) setup[7:0]  <= pwdata[7:0];
      if (pstrb[1]) setup[15:8] <= pwdata[15:8];
    end
  end

  // the done pin comes from the port converter, outside this clock domain;
  // only done_sync is read, and the pin must stay high longer than one clock or a
  // done can be lost
  // two-stage synchroniser for the done pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
    end else begin
      done_meta <= port_done_pin;
      done_sync <= done_meta;
    end
  end

  // 16.16 fixed point: integer factor above the point, fraction below;
  // bits below the point are cut, not rounded, and outside an event-timing
  // command raw values pass untouched; the factors are levels from the
  // calibration store and must not change while a strobe is taken; the
  // multiply is combinational and may need a pipeline stage in silicon
  // calibration: raw times integer.fraction factor
  wire [63:0] cal_prod = {32'h00000000, meas_in} *
                         {32'h00000000, cal_factor_integer, cal_factor_fraction};
  wire [31:0] cal_val  = cal_prod[CAL_FRAC_W +: 32];
  wire [31:0] next_meas = (cal_use && evt_active) ? cal_val : meas_in;

  // meas_out keeps the last result until the next strobe;
  // the valid strobe follows the raw strobe by one clock
  // measurement output register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_out       <= 32'h00000000;
      meas_out_valid <= 1'b0;
    end else begin
      meas_out_valid <= meas_in_valid;
      if (meas_in_valid) meas_out <= next_meas;
    end
  end

  // code bit 2 enables, bit 1 picks the flight-time point (cycle or sequence),
  // bit 0 picks the temperature point: one pass or the whole sequence;
  // codes 000b..011b never request a calibration;
  // is_tof selects the flight-time column, is_seq the sequence row
  // autocal trigger point for a code: tof or temperature, cycle or sequence
  function automatic logic cal_at(input logic [2:0] code, input logic is_tof,
                                  input logic is_seq);
    if (!code[2]) cal_at = 1'b0;                    // 000b..011b disabled
    else if (is_tof) cal_at = (code[1] == is_seq);  // 10x cycle, 11x sequence
    else cal_at = (code[0] == is_seq);              // x0 cycle, x1 sequence
  endfunction

  // trigger points only count while an event-timing command runs;
  // temperature triggers come from the engine's start strobes
  wire next_cal = evt_active &&
                  ((tof_cycle_start && cal_at(cal_cfg, 1'b1, 1'b0)) ||
                   (tof_seq_start   && cal_at(cal_cfg, 1'b1, 1'b1)) ||
                   (cycle_start     && cal_at(cal_cfg, 1'b0, 1'b0)) ||
                   (seq_start       && cal_at(cal_cfg, 1'b0, 1'b1)));

  // one clock per trigger point; the calibrate engine must take it then
  // calibrate request pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) calibrate_req <= 1'b0;
    else        calibrate_req <= next_cal;
  end

  // temperature sequence engine: snapshots port code and counts on temp_go;
  // preamble passes run first and their results are dropped;
  // temp_go while a sequence runs is ignored by the engine;
  // port_done reaches the engine through the synchroniser above
  temp_sequencer u_tseq (
    .clk          (clk),
    .rst_n        (rst_n),
    .go           (temp_go),
    .port_code    (temp_port_select),
    .pre_count    (preamble_cycle_count),
    .meas_count   (temp_cycle_count),
    .port_done    (done_sync),
    .busy         (temp_busy),
    .seq_start    (seq_start),
    .cycle_start  (cycle_start),
    .port_stim    (port_stim),
    .store_result (store_result),
    .result_port  (result_port),
    .in_preamble  (in_preamble)
  );

  // checkers for the setup fields, sampled on clk, off during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a raw strobe with the calibration applied, bypassed, or outside a command
  sequence s_meas_cal;
    meas_in_valid && cal_use && evt_active;
  endsequence
  sequence s_meas_plain;
    meas_in_valid && !cal_use;
  endsequence
  sequence s_meas_idle;
    meas_in_valid && !evt_active;
  endsequence

  a_cal_applied: assert property (s_meas_cal |=> meas_out == $past(cal_val) && meas_out_valid)
    else $error("calibration not applied");
  a_cal_bypass: assert property (s_meas_plain |=> meas_out == $past(meas_in))
    else $error("raw measurement altered");
  a_cal_idle: assert property (s_meas_idle |=> meas_out == $past(meas_in))
    else $error("calibration applied outside a command");

  // autocalibration: off codes, then one check per trigger kind
  a_autocal_off: assert property (!cal_cfg[2] && !$past(cal_cfg[2]) |-> !calibrate_req)
    else $error("autocal with disabled code");
  a_autocal_tseq: assert property (seq_start && evt_active && cal_cfg == 3'h5 |=> calibrate_req)
    else $error("missing autocal at temperature sequence");
  a_autocal_tofc: assert property (tof_cycle_start && evt_active && cal_cfg == 3'h4 |=> calibrate_req)
    else $error("missing autocal at tof cycle");
  a_autocal_pass: assert property (cycle_start && evt_active && cal_cfg == 3'h4 |=> calibrate_req)
    else $error("missing autocal at temperature pass");
  a_autocal_tofs: assert property (tof_seq_start && evt_active && cal_cfg == 3'h7 |=> calibrate_req)
    else $error("missing autocal at tof sequence");

  // temperature results and register writes
  a_preamble_store: assert property (in_preamble |=> !store_result)
    else $error("preamble result stored");
  a_setup_write: assert property (wr_set && pstrb[1:0] == 2'h3 |=> setup == $past(pwdata[15:0]))
    else $error("setup write lost");
endmodule
`default_nettype wire

// *** shared/evtseq_pkg.sv ***
/*
  shared constants for the event-sequence calibration and temperature
  configuration block: apb offsets, field positions, reset value, codes.
  assumes a 32-bit apb bus and a 16-bit setup register in the low half.
*/
package evtseq_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_SETUP      = 12'h000;  // setup register
  localparam logic [11:0] OFS_STATUS     = 12'h004;  // sequencer status
  localparam logic [11:0] OFS_RESULT     = 12'h008;  // last measurement out
  // setup register field positions
  localparam int          CYC_CNT_LSB    = 11;       // temp_cycle_count [15:11]
  localparam int          CAL_USE_BIT    = 10;       // calibration use
  localparam int          CAL_CFG_LSB    = 7;        // autocal code [9:7]
  localparam int          PORT_SEL_LSB   = 5;        // temp_port_select [6:5]
  localparam int          PRE_LSB        = 2;        // preamble_cycle_count [4:2]
  localparam int          PORT_TIME_LSB  = 0;        // port timing, stored only
  localparam logic [15:0] SETUP_RESET    = 16'h0000; // value after reset
  // port select codes
  localparam logic [1:0]  PORTS_T1_T3    = 2'h0;
  localparam logic [1:0]  PORTS_T2_T4    = 2'h1;
  localparam logic [1:0]  PORTS_T1_T3_T2 = 2'h2;
  localparam logic [1:0]  PORTS_ALL      = 2'h3;
  // calibration factor fraction width
  localparam int          CAL_FRAC_W     = 16;
  // temperature sequencer states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CYCLE = 3'b001,
    S_STIM  = 3'b010,
    S_WAIT  = 3'b011,
    S_NEXT  = 3'b100
  } tseq_state_t;
endpackage

// *** hw/temp_sequencer.sv ***
/*
  temperature sequence engine: runs preamble passes, then measurement
  passes, each pass stimulating ports in the order the port code gives.
  assumes port_done is already synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module temp_sequencer (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       go,            // start a sequence
  input  wire logic [1:0]                 port_code,     // port select code
  input  wire logic [2:0]                 pre_count,     // preamble passes
  input  wire logic [4:0]                 meas_count,    // real passes minus one
  input  wire logic                       port_done,     // port conversion done
  output logic                            busy,          // sequence running
  output logic                            seq_start,     // sequence begins
  output logic                            cycle_start,   // one pass begins
  output logic [3:0]                      port_stim,     // one-hot T1..T4
  output logic                            store_result,  // keep this result
  output logic [1:0]                      result_port,   // port of the result
  output logic                            in_preamble    // preamble pass running
);
  import evtseq_pkg::*;

  tseq_state_t state;        // current state
  logic [1:0]  code_q;       // port code held for the sequence
  logic        done_q;       // port_done one clock late, for its rising edge
  logic [2:0]  pre_left;     // preamble passes still to run
  logic [4:0]  meas_left;    // real passes still to run after this
  logic [1:0]  idx;          // position within a pass

  // port number at a position of the pass
  function automatic logic [1:0] port_at(input logic [1:0] code, input logic [1:0] i);
    case (i)
      2'h0:    port_at = (code == PORTS_T2_T4) ? 2'h1 : 2'h0;
      2'h1:    port_at = (code == PORTS_T2_T4) ? 2'h3 : 2'h2;
      2'h2:    port_at = 2'h1;
      default: port_at = 2'h3;
    endcase
  endfunction

  wire [1:0] cur_port = port_at(code_q, idx);                          // port in use
  wire [1:0] last_idx = code_q[1] ? (code_q[0] ? 2'h3 : 2'h2) : 2'h1; // pass end
  // a done level left high from the previous port must not end the next one
  wire       done_rise = port_done && !done_q;                          // fresh done

  assign busy        = (state != S_IDLE);
  assign seq_start   = go && (state == S_IDLE);
  assign cycle_start = (state == S_CYCLE);
  assign in_preamble = busy && (pre_left != 3'h0);

  // pass and port stepping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= S_IDLE;
      code_q       <= 2'h0;
      done_q       <= 1'b0;
      pre_left     <= 3'h0;
      meas_left    <= 5'h00;
      idx          <= 2'h0;
      port_stim    <= 4'h0;
      store_result <= 1'b0;
      result_port  <= 2'h0;
    end else begin
      done_q       <= port_done;
      store_result <= 1'b0;
      case (state)
        S_IDLE: begin
          if (go) begin
            code_q    <= port_code;
            pre_left  <= pre_count;
            meas_left <= meas_count;
            state     <= S_CYCLE;
          end
        end
        S_CYCLE: begin
          idx   <= 2'h0;
          state <= S_STIM;
        end
        S_STIM: begin
          port_stim <= 4'h1 << cur_port;
          state     <= S_WAIT;
        end
        S_WAIT: begin
          if (done_rise) begin
            port_stim    <= 4'h0;
            result_port  <= cur_port;
            store_result <= (pre_left == 3'h0);   // preamble results dropped
            if (idx == last_idx) begin
              state <= S_NEXT;
            end else begin
              idx   <= idx + 2'h1;
              state <= S_STIM;
            end
          end
        end
        S_NEXT: begin
          if (pre_left != 3'h0) begin
            pre_left <= pre_left - 3'h1;
            state    <= S_CYCLE;
          end else if (meas_left != 5'h00) begin
            meas_left <= meas_left - 5'h01;
            state     <= S_CYCLE;
          end else begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_preamble_drop: assert property (store_result |-> $past(pre_left) == 3'h0)
    else $error("result kept from a preamble pass");
  a_zero_preamble: assert property (seq_start && pre_count == 3'h0 |=> !in_preamble)
    else $error("preamble pass with zero count");
  a_port_first: assert property (cycle_start && code_q == PORTS_T2_T4 |-> ##2 port_stim == 4'h2)
    else $error("wrong first port for code 01");
  a_port_order: assert property (cycle_start && code_q == PORTS_ALL |-> ##2 port_stim == 4'h1)
    else $error("wrong first port for code 11");
  a_stim_onehot: assert property ($onehot0(port_stim))
    else $error("more than one port stimulated");
endmodule
`default_nettype wire

// *** hw/_unused_guard.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** verif/testbench.sv ***
/*
  self-checking bench for the event-sequence setup block: apb access,
  calibrated measurements, autocalibration triggers, temperature passes.
  assumes the design package and a 125 mhz clock; bench plays every party.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import evtseq_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;   // clock, reset, apb controls
  logic        evt_active = 0, tof_cycle_start = 0, tof_seq_start = 0;  // event sequencer inputs
  logic        temp_go = 0, port_done_pin = 0, meas_in_valid = 0;       // temperature and measurement
  logic [11:0] paddr = 0;                                               // apb address
  logic [31:0] pwdata = 0, meas_in = 0, rd;                             // write, raw data, read back
  logic [3:0]  pstrb = 0, last_stim = 0;                                // lanes, previous port drive
  logic [15:0] cal_factor_integer = 0, cal_factor_fraction = 0, model;  // factors, register model
  logic        er;                                                      // last apb error
  wire logic   pready, pslverr, meas_out_valid, calibrate_req, store_result, temp_busy;
  wire logic [31:0] prdata, meas_out;
  wire logic [3:0]  port_stim;
  wire logic [1:0]  result_port;
  int          errors = 0, checks_done = 0;                             // verdict counters
  int          stq[$], sq[$], cq = 0;                                   // stimulated, stored ports, cal pulses
  int          ord[4][4] = '{'{0, 2, 0, 0}, '{1, 3, 0, 0}, '{0, 2, 1, 0}, '{0, 2, 1, 3}};
  int          len[4] = '{2, 2, 3, 4};                                  // ports per pass

  event_sequence_config i_event_sequence_config (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .evt_active(evt_active), .tof_cycle_start(tof_cycle_start),
    .tof_seq_start(tof_seq_start), .temp_go(temp_go), .port_done_pin(port_done_pin), .meas_in(meas_in),
    .meas_in_valid(meas_in_valid), .cal_factor_integer(cal_factor_integer),
    .cal_factor_fraction(cal_factor_fraction), .meas_out(meas_out), .meas_out_valid(meas_out_valid),
    .calibrate_req(calibrate_req), .port_stim(port_stim), .store_result(store_result),
    .result_port(result_port), .temp_busy(temp_busy));

  // free-running clock
  always #4 clk = ~clk;

  // one comparison, counted
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // counts, verdict, end of run
  task final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one apb transfer, entered just after a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk) penable <= 1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);   // idle edge: the next call never reassigns psel in this step
  endtask

  // full write of the setup register, model follows
  task wr(input logic [15:0] v);
    apb(1, OFS_SETUP, {16'h0000, v}, 4'h3);
    model = v;
  endtask

  // one raw measurement against the calibration model
  task meas(input logic [31:0] x, input logic ev);
    logic [63:0] p;
    p = x * {cal_factor_integer, cal_factor_fraction};
    evt_active <= ev; meas_in <= x; meas_in_valid <= 1;
    @(posedge clk) meas_in_valid <= 0;
    @(posedge clk);
    chk("meas_out_valid", meas_out_valid, 1);
    chk("meas_out", meas_out, (model[10] && ev) ? p[47:16] : x);
  endtask

  // one flight-time event, then the calibrate request a cycle later
  task acal(input logic seq, input logic ev);
    evt_active <= ev;
    if (seq) tof_seq_start <= 1;
    else tof_cycle_start <= 1;
    @(posedge clk) tof_seq_start <= 0;
    tof_cycle_start <= 0;
    @(posedge clk) chk("calibrate_req", calibrate_req, model[9] && ev && (model[8] == seq));
  endtask

  // port model: done follows the drive, monitor logs drive starts and stores
  always @(posedge clk) begin
    if (store_result === 1'b1) sq.push_back(int'(result_port));
    if (calibrate_req === 1'b1) cq++;
    if (port_stim !== 4'h0 && last_stim === 4'h0) stq.push_back(port_stim[1] ? 1 : port_stim[2] ? 2 : port_stim[3] ? 3 : 0);
    last_stim <= port_stim;
    port_done_pin <= (port_stim !== 4'h0);
  end

  // one temperature sequence against the pass model
  task temp(input logic [1:0] ps, input logic [2:0] pre, input logic [4:0] cyc, input logic [2:0] cal,
            input logic ev);
    int n;
    wr({cyc, 1'b0, cal, ps, pre, 2'b00});
    stq.delete(); sq.delete(); n = 0; cq = 0;
    temp_go <= 1; evt_active <= ev;
    @(posedge clk) temp_go <= 0;
    do begin @(posedge clk); n++; end while (temp_busy !== 1'b0 && n < 5000);
    if (n >= 5000) errors++;
    chk("stim count", stq.size(), (pre + cyc + 1) * len[ps]);
    chk("store count", sq.size(), (cyc + 1) * len[ps]);
    chk("cal count", cq, (ev && cal[2]) ? (cal[0] ? 1 : pre + cyc + 1) : 0);
    foreach (stq[k]) chk("stim port", stq[k], ord[ps][k % len[ps]]);
    foreach (sq[k]) chk("store port", sq[k], ord[ps][k % len[ps]]);
  endtask

  // main sequence
  initial begin
    logic [15:0] v;
    void'($urandom(32'hD4AA));
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, OFS_SETUP, 32'h0, 4'h0);
    chk("setup reset", rd, {16'h0000, SETUP_RESET});
    apb(1, 12'h0FC, 32'hFFFFFFFF, 4'hF);
    chk("unmapped write error", er, 1);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      wr(v);
      apb(0, OFS_SETUP, 32'h0, 4'h0);
      chk("setup readback", rd, {16'h0000, v});
    end
    apb(1, OFS_SETUP, 32'hFFFFFFFF, 4'h1);
    model[7:0] = 8'hFF;
    apb(0, OFS_SETUP, 32'h0, 4'h0);
    chk("setup lane write", rd, {16'h0000, model});
    cal_factor_integer <= 16'($urandom_range(0, 3));
    cal_factor_fraction <= 16'($urandom);
    for (int i = 0; i < 4; i++) begin
      wr({5'h00, i[1], 10'h000});
      meas($urandom, i[0]);
    end
    for (int c = 0; c < 8; c++) begin
      wr({6'h00, c[2:0], 7'h00});
      acal(0, 1);
      acal(1, 1);
      acal(c[0], 0);
    end
    evt_active <= 0;
    for (int t = 0; t < 4; t++) temp(t[1:0], 3'($urandom_range(0, 3)), {4'h0, t[0]}, 3'(t + 4), t != 2);
    temp(2'h3, 3'h7, 5'h02, 3'h3, 1);
    final_report;
  end

  // hang guard, far beyond the expected run
  initial begin
    #400000;
    errors++;
    final_report;
  end
endmodule
`default_nettype wire
